// File: rtl/local_switch_register.sv
// Purpose: local front panel switch register with staggered source change
// Assumes: one 200 MHz clock; touch inputs synchronised inside
// Notes:   no register bus, every control and status bit is a port
//          source changes are staggered so both sources never swap in one cycle
//          the two top lamps stay dark while local data is shown
//
// Operation
// [R1] sixteen bits, each touch toggles, local only
// [R2] load and return touches give one event
// [R3] clear touch in local zeroes all bits
// [R4] clear ignored while remote selected
// [R5] to local: enable register, then inhibit remote
// [R6] to remote: enable remote, then inhibit register
// [R7] delayed change-over avoids false gate or flag
// [R8] touch sensing enabled only in local
// [R9] eighteen lamps show selected source ones
// [R10] synchronise touches, act on rising edge

`timescale 1ns/100ps
`default_nettype none

module local_switch_register
    import switch_register_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // operator panel
    input  wire logic                  source_local,
    input  wire logic [DATA_BITS-1:0]  bit_touch,
    input  wire logic                  load_touch,
    input  wire logic                  return_touch,
    input  wire logic                  clear_touch,
    // remote source state shown on lamps
    input  wire logic [LAMP_COUNT-1:0] remote_lamp_data,
    // outputs
    output var logic [DATA_BITS-1:0]   local_data,
    output logic                       load_event,
    output logic                       return_event,
    output var logic                   local_select,
    output var logic                   remote_inhibit,
    output var logic                   sense_enable,
    output var logic [LAMP_COUNT-1:0]  lamp
);

    touch_bus_if touches ();

    source_state_t              state;
    source_state_t              next_state;
    logic [STAGGER_WIDTH-1:0]   count;
    logic [STAGGER_WIDTH-1:0]   next_count;
    logic                       next_local_select;
    logic                       next_remote_inhibit;
    logic [DATA_BITS-1:0]       next_local_data;
    logic [LAMP_COUNT-1:0]      next_lamp;
    logic                       clear_pulse;
    logic                       stagger_done;
    logic [DATA_BITS-1:0]       toggled;
    logic [LAMP_COUNT-1:0]      local_items;

    // -------------------------------------------------------------------
    // touch detection
    // -------------------------------------------------------------------
    // a touch held while entering local gives nothing until it is released
    // and touched again, so a resting finger cannot flip a bit
    assign touches.level[DATA_BITS-1:0] = bit_touch;
    assign touches.level[LOAD_INDEX] = load_touch;
    assign touches.level[RETURN_INDEX] = return_touch;
    assign touches.level[TOUCH_COUNT] = clear_touch;
    assign touches.sense_enable = local_select;   // R8

    touch_edge edge_detect (
        .clock (clock),
        .rst   (rst),
        .bus   (touches)
    );

    // -------------------------------------------------------------------
    // panel events and status
    // -------------------------------------------------------------------
    assign load_event = touches.pulse[LOAD_INDEX];       // R2
    assign return_event = touches.pulse[RETURN_INDEX];   // R2
    assign sense_enable = local_select;                  // R8

    // -------------------------------------------------------------------
    // clear request
    // -------------------------------------------------------------------
    // detector pulses are masked from the second remote cycle on; this term also ties
    // the clear to local selection so remote can never preset the bits
    assign clear_pulse = touches.pulse[TOUCH_COUNT] & local_select;   // R3 R4

    // -------------------------------------------------------------------
    // source selection sequencer
    // -------------------------------------------------------------------
    // enabling the register and inhibiting the remote source in one cycle
    // could glitch the gate and flag lines, so the two are staggered
    assign stagger_done = (count == STAGGER_ZERO);

    always_comb begin
        next_state = state;
        next_count = count;
        next_local_select = local_select;
        next_remote_inhibit = remote_inhibit;
        case (state)
            SRC_REMOTE: begin
                // register enabled first, remote inhibit follows later
                if (source_local) begin
                    next_local_select = 1'b1;   // R5
                    next_count = STAGGER_LAST;
                    next_state = SRC_TO_LOCAL;
                end
            end
            SRC_TO_LOCAL: begin
                // a change of the switch here is taken after the stagger
                if (!stagger_done) begin
                    next_count = count - 1'b1;   // R7
                end else begin
                    next_remote_inhibit = 1'b1;   // R5
                    next_state = SRC_LOCAL;
                end
            end
            SRC_LOCAL: begin
                // remote released first, register inhibited later
                if (!source_local) begin
                    next_remote_inhibit = 1'b0;   // R6
                    next_count = STAGGER_LAST;
                    next_state = SRC_TO_REMOTE;
                end
            end
            SRC_TO_REMOTE: begin
                // register stays enabled until the remote source is live
                if (!stagger_done) begin
                    next_count = count - 1'b1;   // R7
                end else begin
                    next_local_select = 1'b0;   // R6
                    next_state = SRC_REMOTE;
                end
            end
            default: begin
                next_state = SRC_REMOTE;
                next_count = STAGGER_ZERO;
                next_local_select = 1'b0;
                next_remote_inhibit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= SRC_REMOTE;
            count <= STAGGER_ZERO;
            local_select <= 1'b0;
            remote_inhibit <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            local_select <= next_local_select;
            remote_inhibit <= next_remote_inhibit;
        end
    end

    // -------------------------------------------------------------------
    // local data, one toggle per bit
    // -------------------------------------------------------------------
    // clear wins over a toggle that lands in the same cycle
    for (genvar b = 0; b < DATA_BITS; b++) begin : g_toggle
        always_comb begin
            if (clear_pulse) begin
                toggled[b] = DATA_CLEAR[b];   // R3
            end else if (touches.pulse[b]) begin
                toggled[b] = ~local_data[b];   // R1
            end else begin
                toggled[b] = local_data[b];
            end
        end
    end

    always_comb begin
        next_local_data = toggled;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            local_data <= DATA_CLEAR;
        end else begin
            local_data <= next_local_data;
        end
    end

    // -------------------------------------------------------------------
    // lamps, one cycle behind the selected source
    // -------------------------------------------------------------------
    // local has no items behind the two top lamps, so they stay dark
    assign local_items = LAMP_COUNT'(local_data);

    for (genvar n = 0; n < LAMP_COUNT; n++) begin : g_lamp
        always_comb begin
            if (remote_inhibit) begin
                next_lamp[n] = local_items[n];   // R9
            end else begin
                next_lamp[n] = remote_lamp_data[n];   // R9
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lamp <= '0;
        end else begin
            lamp <= next_lamp;
        end
    end

endmodule

`default_nettype wire

// File: rtl/switch_register_pkg.sv
// Purpose: constants and types shared by the local switch register design
// Assumes: one 200 MHz system clock
// Notes:   staggered source change delays are given in ns and converted to cycles

package switch_register_pkg;

    // -------------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------------
    localparam int unsigned DATA_BITS = 16;
    localparam int unsigned LAMP_COUNT = 18;
    localparam int unsigned TOUCH_COUNT = DATA_BITS + 2;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int unsigned CLOCK_MHZ = 200;
    localparam int unsigned STAGGER_NS = 100;
    localparam int unsigned STAGGER_CYCLES = (STAGGER_NS * CLOCK_MHZ + 999) / 1000;
    localparam int unsigned STAGGER_WIDTH = $clog2(STAGGER_CYCLES + 1);
    localparam logic [STAGGER_WIDTH-1:0] STAGGER_LAST =
        STAGGER_WIDTH'(STAGGER_CYCLES - 1);
    localparam logic [STAGGER_WIDTH-1:0] STAGGER_ZERO = '0;

    // -------------------------------------------------------------------
    // reset values and positions
    // -------------------------------------------------------------------
    localparam logic [DATA_BITS-1:0] DATA_CLEAR = 16'h0000;
    localparam int unsigned LOAD_INDEX = DATA_BITS;
    localparam int unsigned RETURN_INDEX = DATA_BITS + 1;

    typedef enum logic [1:0] {
        SRC_REMOTE,
        SRC_TO_LOCAL,
        SRC_LOCAL,
        SRC_TO_REMOTE
    } source_state_t;

endpackage

// File: rtl/touch_bus_if.sv
// Purpose: carries touch detect pulses between the edge detector and the top
// Assumes: single clock domain
// Notes:   raw touches go in, one-cycle pulses come out

`timescale 1ns/100ps
`default_nettype none

interface touch_bus_if
    import switch_register_pkg::*;
();
    logic [TOUCH_COUNT:0] level;
    logic [TOUCH_COUNT:0] pulse;
    logic                 sense_enable;

    modport detector (input level, input sense_enable, output pulse);
    modport user (output level, output sense_enable, input pulse);
endinterface

`default_nettype wire

// File: rtl/touch_edge.sv
// Purpose: synchronise touch levels and produce one pulse per touch
// Assumes: touch inputs may be asynchronous to the clock
// Notes:   pulses only for edges sampled while sensing is enabled, seen one cycle later

`timescale 1ns/100ps
`default_nettype none

module touch_edge
    import switch_register_pkg::*;
(
    // clock and reset
    input  wire logic    clock,
    input  wire logic    rst,
    // touch path
    touch_bus_if.detector bus
);

    logic [TOUCH_COUNT:0] sync_a;
    logic [TOUCH_COUNT:0] sync_b;
    logic [TOUCH_COUNT:0] last;
    logic [TOUCH_COUNT:0] next_last;
    logic [TOUCH_COUNT:0] next_pulse;

    // -------------------------------------------------------------------
    // rising edge detect, masked when sensing is off
    // -------------------------------------------------------------------
    always_comb begin
        next_last = bus.sense_enable ? sync_b : '1;   // R8
        next_pulse = next_last & ~last;               // R10
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
            last <= '1;
            bus.pulse <= '0;
        end else begin
            sync_a <= bus.level;
            sync_b <= sync_a;
            last <= next_last;
            bus.pulse <= bus.sense_enable ? next_pulse : '0;
        end
    end

endmodule

`default_nettype wire

// File: sim/switch_register_monitor.sv
// Purpose: port checker for the switch register
// Assumes: one clock, async reset
// Notes:   bound to the top module
`timescale 1ns/100ps
`default_nettype none
module switch_register_monitor
    import switch_register_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic                  clear_touch,
    input wire logic [LAMP_COUNT-1:0] remote_lamp_data,
    input wire logic [DATA_BITS-1:0]  local_data,
    input wire logic                  load_event,
    input wire logic                  return_event,
    input wire logic                  local_select,
    input wire logic                  remote_inhibit,
    input wire logic                  sense_enable,
    input wire logic [LAMP_COUNT-1:0] lamp
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_inh_late;
        !remote_inhibit ##20 remote_inhibit;
    endsequence
    sequence s_sel_late;
        local_select ##20 !local_select;
    endsequence
    sequence s_clr_held;
        $rose(clear_touch) && local_select ##1 (clear_touch && local_select)[*5];
    endsequence
    AST_TO_LOCAL: assert property ($rose(local_select) |-> s_inh_late)
        else $error("inhibit not late");
    AST_TO_REMOTE: assert property ($fell(remote_inhibit) |-> s_sel_late)
        else $error("select not late");
    AST_NO_GAP: assert property (remote_inhibit |-> local_select)
        else $error("both sources off");
    AST_SENSE: assert property (sense_enable == local_select)
        else $error("sensing wrong");
    AST_HOLD: assert property (!local_select [*3] |=> $stable(local_data))
        else $error("data moved in remote");
    AST_CLEAR: assert property (s_clr_held |-> local_data == DATA_CLEAR)
        else $error("clear missed");
    AST_PULSE: assert property (load_event || return_event |=> !load_event && !return_event)
        else $error("event too long");
    AST_EVT_REM: assert property (!local_select [*4] |-> !load_event && !return_event)
        else $error("event in remote");
    AST_LAMP: assert property (local_select && remote_inhibit |=> lamp == {2'h0, $past(local_data)})
        else $error("local lamp wrong");
    AST_LAMP_REM: assert property (!local_select |=> lamp == $past(remote_lamp_data))
        else $error("remote lamp wrong");
endmodule
bind local_switch_register switch_register_monitor switch_register_monitor_inst (
    .clock(clock), .rst(rst), .clear_touch(clear_touch), .remote_lamp_data(remote_lamp_data),
    .local_data(local_data), .load_event(load_event), .return_event(return_event),
    .local_select(local_select), .remote_inhibit(remote_inhibit),
    .sense_enable(sense_enable), .lamp(lamp)
);
`default_nettype wire

// File: sim/panel_model.sv
// Purpose: operator panel touches and remote source items
// Assumes: driven on the falling edge
// Notes:   ctl_touch is load, return, clear
`timescale 1ns/100ps
`default_nettype none
module panel_model
    import switch_register_pkg::*;
(
    input  wire logic                  clock,
    output var logic [DATA_BITS-1:0]   bit_touch,
    output var logic [2:0]             ctl_touch,
    output var logic [LAMP_COUNT-1:0]  remote_lamp_data
);
    initial begin
        bit_touch = '0;
        ctl_touch = '0;
        remote_lamp_data = '0;
    end
    // remote items change every cycle
    always @(negedge clock) remote_lamp_data <= LAMP_COUNT'($urandom);
    // a touch is held for several cycles, then released
    task automatic touch(input int idx);
        @(negedge clock);
        if (idx < 16) bit_touch[idx] = 1'b1;
        else ctl_touch[idx-16] = 1'b1;
        repeat (8) @(negedge clock);
        bit_touch = '0;
        ctl_touch = '0;
        repeat (8) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: self-checking bench for the switch register
// Assumes: 200 MHz clock
// Notes:   expected data is queued, a watcher compares
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import switch_register_pkg::*;
;
    logic                  clock = 1'b0;
    logic                  rst = 1'b1;
    logic                  source_local = 1'b0;
    logic [DATA_BITS-1:0]  bit_touch;
    logic [2:0]            ctl_touch;
    logic [LAMP_COUNT-1:0] remote_lamp_data;
    logic [DATA_BITS-1:0]  local_data;
    logic                  load_event;
    logic                  return_event;
    logic                  local_select;
    logic                  remote_inhibit;
    logic                  sense_enable;
    logic [LAMP_COUNT-1:0] lamp;
    logic [DATA_BITS-1:0]  exp_data = '0;
    logic [DATA_BITS-1:0]  last_data = '0;
    logic [DATA_BITS-1:0]  exp_q[$];
    logic [15:0]           n_load = '0;
    logic [15:0]           n_ret = '0;
    int                    n_fail = 0;
    int                    cmp_count = 0;
    local_switch_register local_switch_register_inst (
        .clock(clock), .rst(rst), .source_local(source_local), .bit_touch(bit_touch),
        .load_touch(ctl_touch[0]), .return_touch(ctl_touch[1]), .clear_touch(ctl_touch[2]),
        .remote_lamp_data(remote_lamp_data), .local_data(local_data),
        .load_event(load_event), .return_event(return_event), .local_select(local_select),
        .remote_inhibit(remote_inhibit), .sense_enable(sense_enable), .lamp(lamp)
    );
    panel_model panel_model_inst (
        .clock(clock), .bit_touch(bit_touch), .ctl_touch(ctl_touch),
        .remote_lamp_data(remote_lamp_data)
    );
    initial forever #2.5 clock = ~clock;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tog(input int idx);
        exp_data[idx] = ~exp_data[idx];
        exp_q.push_back(exp_data);
        panel_model_inst.touch(idx);
    endtask
    // any change of local_data takes the oldest note, and fails when none is queued
    always @(negedge clock) begin
        if (local_data !== last_data) begin
            if (exp_q.size() == 0) chk(local_data, last_data);
            else chk(local_data, exp_q.pop_front());
            last_data = local_data;
        end
        if (load_event === 1'b1) n_load <= n_load + 16'h0001;
        if (return_event === 1'b1) n_ret <= n_ret + 16'h0001;
    end
    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h7BEC11EA));
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        panel_model_inst.touch(3);
        panel_model_inst.touch(16);
        panel_model_inst.touch(18);
        source_local = 1'b1;
        repeat (4) @(negedge clock);
        chk({14'h0000, remote_inhibit, local_select}, 16'h0001);
        repeat (26) @(negedge clock);
        chk({14'h0000, sense_enable, remote_inhibit}, 16'h0003);
        chk(lamp[DATA_BITS-1:0], exp_data);
        for (int i = 0; i < 16; i++) tog(i);
        repeat (6) tog($urandom_range(15));
        repeat (2) panel_model_inst.touch(16);
        panel_model_inst.touch(17);
        chk(lamp[DATA_BITS-1:0], exp_data);
        chk({14'h0000, lamp[LAMP_COUNT-1:DATA_BITS]}, 16'h0000);
        exp_data = DATA_CLEAR;
        exp_q.push_back(DATA_CLEAR);
        panel_model_inst.touch(18);
        source_local = 1'b0;
        repeat (4) @(negedge clock);
        chk({14'h0000, remote_inhibit, local_select}, 16'h0001);
        repeat (26) @(negedge clock);
        chk({15'h0000, sense_enable}, 16'h0000);
        panel_model_inst.touch(18);
        panel_model_inst.touch(5);
        chk(local_data, exp_data);
        chk(n_load, 16'h0002);
        chk(n_ret, 16'h0001);
        chk(16'(exp_q.size()), 16'h0000);
        chk({15'h0000, remote_inhibit}, 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
